/* design/query_cfg.svh */
`ifndef QUERY_CFG_SVH
`define QUERY_CFG_SVH

// query register addresses
`define REG_PARAM      8'h30
`define REG_TEMP       8'h31
`define REG_STATUS     8'h32
`define REG_IDENT      8'h33
`define REG_RSVD       8'h34
`define REG_CAL        8'h35
`define REG_USER       8'h36
`define REG_SHIFT      8'h37

// instruction bytes following each address
`define ARGS_SEL       3'd1
`define ARGS_STORE     3'd3
`define ARGS_SHIFT     3'd7

// selectors
`define SEL_LAST_FREQ  4'h6
`define SEL_ATTEN      4'h7
`define SEL_CHAIN      4'h8
`define ID_SERIAL      4'h0
`define ID_REVS        4'h1
`define ID_DATES       4'h2
`define ID_IFACE       4'h3
`define ID_MFG         4'h4
`define ID_CAL         4'h5

// reply byte count and store fetch length
`define RESP_BYTES     4'h8

// status word field positions
`define ST_ACCESSED    8
`define ST_EXT_LOCK    9
`define ST_REF_OUT     10
`define ST_REF_RATE    11
`define ST_PWR_LO      12
`define ST_LOOP_GAIN   15
`define ST_QUICK       17
`define ST_LO1_OUT     18
`define ST_CHAIN_PWR   24
`define ST_CONV_BYP    25
`define ST_EXT_IF2     26
`define ST_IF3_BYP     27
`define ST_IF2_FILT    29
`define ST_BANK1       30
`define ST_BANK2       32
`define ST_INVERT      33
`define ST_FRONT_AMP   34
`define ST_AUTO_GAIN   35
`define ST_AUTO_AMP    36

`endif

/* design/query_pkg.sv */
`default_nettype none
package query_pkg;

  typedef logic [55:0] freq_t;

  // live tuning and chain values reported by parameter and temperature queries
  typedef struct packed {
    freq_t [6:0] freq;        // rf, if1, if2, if3, lo1, lo2, lo3
    logic [7:0]  rf_att1;
    logic [7:0]  rf_att2;
    logic [7:0]  ext_if_att;
    logic [7:0]  if3_att1;
    logic [7:0]  if3_att2;
    logic [15:0] route_word;
    logic [15:0] chain_gain;
    logic [31:0] temperature;
  } params_s;

  // operating conditions for the status query
  typedef struct packed {
    logic [7:0] lock_flags;
    logic       external_lock_on;
    logic       reference_output_on;
    logic       reference_output_rate;
    logic [2:0] osc_powered;
    logic [1:0] synth_loop_gain;
    logic       quick_tuning;
    logic       first_oscillator_routed_out;
    logic       chain_powered;
    logic       conversion_bypass;
    logic       external_second_if_select;
    logic       third_stage_bypass;
    logic       second_if_filter_choice;
    logic [1:0] third_if_bank_one_choice;
    logic       third_if_bank_two_choice;
    logic       spectral_inversion;
    logic       front_amp_on;
    logic       automatic_gain_on;
    logic       automatic_front_amp;
  } status_s;

  // identity data
  typedef struct packed {
    logic [31:0] serial_number;
    logic [7:0]  interface_code;
    logic [31:0] hw_revision;
    logic [31:0] fw_revision;
    logic [31:0] mfg_date;
    logic [31:0] cal_date;
  } identity_s;

  // store write port, region 0 calibration, 1 user
  typedef struct packed {
    logic        en;
    logic        region;
    logic [15:0] addr;
    logic [7:0]  data;
  } store_wr_s;

  typedef enum logic [2:0] {
    st_addr,
    st_args,
    st_build,
    st_fetch,
    st_shift,
    st_skip
  } state_e;

endpackage
`default_nettype wire

/* design/store_mem.sv */
`default_nettype none
module store_mem (
  input  wire logic        mclk,
  input  wire logic        wr_en,
  input  wire logic [16:0] wr_addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic [16:0] rd_addr,
  output var  logic [7:0]  rd_data
);

  logic [7:0] mem [0:131071];

  // one write and one registered read per clock
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

/* design/query_register_responder.sv */
`include "query_cfg.svh"
`default_nettype none
module query_register_responder (
  input  wire logic                mclk,
  input  wire logic                resetn,
  input  wire logic [7:0]          in_byte,
  input  wire logic                in_valid,
  input  wire logic                in_first,
  input  wire logic                rd_req,
  input  wire logic                system_active_marker,
  input  wire query_pkg::params_s  params,
  input  wire query_pkg::status_s  status,
  input  wire query_pkg::identity_s identity,
  input  wire query_pkg::store_wr_s store_wr,
  output var  logic [7:0]          out_byte,
  output var  logic                out_valid,
  output logic                     serial_ready_out
);
  import query_pkg::*;

  state_e      state, next_state;
  logic [7:0]  cmd, next_cmd;
  logic [23:0] args, next_args;
  logic [2:0]  arg_cnt, next_arg_cnt;
  logic [63:0] resp, next_resp;
  logic [3:0]  fetch_cnt, next_fetch_cnt;
  logic [7:0]  next_out_byte;
  logic        next_out_valid;
  logic        accessed, next_accessed;
  logic        accept, is_addr, pop;
  logic [15:0] fetch_addr;
  logic [7:0]  rd_data;
  logic [7:0]  resp_top;
  freq_t       freq_pick;

  // status word assembly, reserved and upper bits zero
  function automatic logic [63:0] status_word(input status_s s, input logic acc);
    logic [63:0] w;
    w = 64'h0;
    w[7:0] = s.lock_flags;
    w[`ST_ACCESSED] = acc;
    w[`ST_EXT_LOCK] = s.external_lock_on;
    w[`ST_REF_OUT] = s.reference_output_on;
    w[`ST_REF_RATE] = s.reference_output_rate;
    w[`ST_PWR_LO +: 3] = s.osc_powered;
    w[`ST_LOOP_GAIN +: 2] = s.synth_loop_gain;
    w[`ST_QUICK] = s.quick_tuning;
    w[`ST_LO1_OUT] = s.first_oscillator_routed_out;
    w[`ST_CHAIN_PWR] = s.chain_powered;
    w[`ST_CONV_BYP] = s.conversion_bypass;
    w[`ST_EXT_IF2] = s.external_second_if_select;
    w[`ST_IF3_BYP] = s.third_stage_bypass;
    w[`ST_IF2_FILT] = s.second_if_filter_choice;
    w[`ST_BANK1 +: 2] = s.third_if_bank_one_choice;
    w[`ST_BANK2] = s.third_if_bank_two_choice;
    w[`ST_INVERT] = s.spectral_inversion;
    w[`ST_FRONT_AMP] = s.front_amp_on;
    w[`ST_AUTO_GAIN] = s.automatic_gain_on;
    w[`ST_AUTO_AMP] = s.automatic_front_amp;
    return w;
  endfunction

  // reply for the register-only queries
  function automatic logic [63:0] build_reply(input logic [7:0] c, input logic [3:0] sel,
                                              input params_s p, input status_s s,
                                              input identity_s id, input logic acc);
    logic [63:0] r;
    r = 64'h0;
    case (c)
      `REG_PARAM: begin
        if (sel <= `SEL_LAST_FREQ) begin
          r = {8'h00, p.freq[sel[2:0]]};
        end else if (sel == `SEL_ATTEN) begin
          r = {16'h0000, p.rf_att1, p.rf_att2, 8'h00, p.ext_if_att,
               p.if3_att1, p.if3_att2};
        end else if (sel == `SEL_CHAIN) begin
          r = {24'h000000, p.chain_gain, 8'h00, p.route_word};
        end
      end
      `REG_TEMP: begin
        r = {32'h00000000, p.temperature};
      end
      `REG_STATUS: begin
        r = status_word(s, acc);
      end
      `REG_IDENT: begin
        case (sel)
          `ID_SERIAL: r = {24'h000000, id.interface_code, id.serial_number};
          `ID_REVS:   r = {id.fw_revision, id.hw_revision};
          `ID_DATES:  r = {id.cal_date, id.mfg_date};
          `ID_IFACE:  r = {56'h0, id.interface_code};
          `ID_MFG:    r = {32'h00000000, id.mfg_date};
          `ID_CAL:    r = {32'h00000000, id.cal_date};
          default:    r = 64'h0;
        endcase
      end
      default: begin
        r = 64'h0;
      end
    endcase
    return r;
  endfunction

  // calibration and user storage share one memory
  store_mem u_store (
    .mclk    (mclk),
    .wr_en   (store_wr.en),
    .wr_addr ({store_wr.region, store_wr.addr}),
    .wr_data (store_wr.data),
    .rd_addr ({cmd == `REG_USER, fetch_addr}),
    .rd_data (rd_data)
  );

  // input taken only while ready; a frame start always carries an address
  assign serial_ready_out = (state == st_addr) || (state == st_args) ||
                            (state == st_shift) || (state == st_skip);
  assign accept = in_valid && serial_ready_out;
  assign is_addr = accept && (in_first || state == st_addr);
  assign fetch_addr = args[23:8] + {13'h0000, fetch_cnt[2:0]};
  assign resp_top = resp[63:56];
  assign pop = (is_addr && in_byte == `REG_SHIFT) ||
               (accept && !is_addr && state == st_shift) ||
               (rd_req && state == st_addr && !accept);

  // helper for reply checks
  always_comb begin
    freq_pick = params.freq[args[2:0]];
  end

  // command sequencer next state
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_args = args;
    next_arg_cnt = arg_cnt;
    next_resp = resp;
    next_fetch_cnt = fetch_cnt;
    next_out_valid = 1'b0;
    next_out_byte = 8'h00;
    next_accessed = accessed | system_active_marker;
    if (pop) begin
      next_resp = {resp[55:0], 8'h00};
    end
    if (accept || pop) begin
      next_out_valid = 1'b1;
      next_out_byte = pop ? resp_top : 8'h00;
    end
    if (is_addr) begin
      next_cmd = in_byte;
      next_args = 24'h000000;
      case (in_byte)
        `REG_PARAM, `REG_TEMP, `REG_STATUS, `REG_IDENT: begin
          next_state = st_args;
          next_arg_cnt = `ARGS_SEL;
        end
        `REG_CAL, `REG_USER: begin
          next_state = st_args;
          next_arg_cnt = `ARGS_STORE;
        end
        `REG_SHIFT: begin
          next_state = st_shift;
          next_arg_cnt = `ARGS_SHIFT;
        end
        default: begin
          next_state = st_skip;
        end
      endcase
    end else begin
      case (state)
        st_args: begin
          if (accept) begin
            next_args = {args[15:0], in_byte};
            next_arg_cnt = arg_cnt - 3'd1;
            if (arg_cnt == 3'd1) begin
              next_fetch_cnt = 4'h0;
              next_state = (cmd == `REG_CAL || cmd == `REG_USER) ? st_fetch : st_build;
            end
          end
        end
        st_build: begin
          next_resp = build_reply(cmd, args[3:0], params, status, identity, accessed);
          next_state = st_addr;
        end
        st_fetch: begin
          next_fetch_cnt = fetch_cnt + 4'h1;
          if (fetch_cnt != 4'h0) begin
            next_resp = {rd_data, resp[63:8]};
          end
          if (fetch_cnt == `RESP_BYTES) begin
            next_state = st_addr;
          end
        end
        st_shift: begin
          if (accept) begin
            next_arg_cnt = arg_cnt - 3'd1;
            if (arg_cnt == 3'd1) begin
              next_state = st_addr;
            end
          end
        end
        st_addr, st_skip: begin
          next_state = state;
        end
        default: begin
          next_state = st_addr;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= st_addr;
      cmd <= 8'h00;
      args <= 24'h000000;
      arg_cnt <= 3'h0;
      resp <= 64'h0;
      fetch_cnt <= 4'h0;
      out_byte <= 8'h00;
      out_valid <= 1'b0;
      accessed <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      args <= next_args;
      arg_cnt <= next_arg_cnt;
      resp <= next_resp;
      fetch_cnt <= next_fetch_cnt;
      out_byte <= next_out_byte;
      out_valid <= next_out_valid;
      accessed <= next_accessed;
    end
  end

  // frequency replies
  a_freq_top_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (state == st_build && cmd == `REG_PARAM && args[3:0] <= `SEL_LAST_FREQ)
    |=> resp == {8'h00, $past(freq_pick)})
    else $error("frequency reply layout wrong");

  a_temp_low_half: assert property (@(posedge mclk) disable iff (!resetn)
    (state == st_build && cmd == `REG_TEMP)
    |=> resp[63:32] == 32'h0 && resp[31:0] == $past(params.temperature))
    else $error("temperature reply layout wrong");

  a_chain_gain_slot: assert property (@(posedge mclk) disable iff (!resetn)
    (state == st_build && cmd == `REG_PARAM && args[3:0] == `SEL_CHAIN)
    |=> resp[39:24] == $past(params.chain_gain) && resp[63:40] == 24'h0)
    else $error("chain gain misplaced");

  a_status_access_bit: assert property (@(posedge mclk) disable iff (!resetn)
    (state == st_build && cmd == `REG_STATUS)
    |=> resp[`ST_ACCESSED] == $past(accessed) && resp[63:37] == 27'h0)
    else $error("status access bit wrong");

  a_ident_bad_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (state == st_build && cmd == `REG_IDENT && args[3:0] > `ID_CAL)
    |=> resp == 64'h0)
    else $error("unknown identity selector not zero");

  a_rsvd_no_query: assert property (@(posedge mclk) disable iff (!resetn)
    (is_addr && in_byte == `REG_RSVD) |=> state == st_skip)
    else $error("reserved address started a query");

  a_fetch_length: assert property (@(posedge mclk) disable iff (!resetn)
    (state != st_fetch ##1 state == st_fetch) |-> ##9 state == st_addr)
    else $error("store fetch length wrong");

  a_busy_not_ready: assert property (@(posedge mclk) disable iff (!resetn)
    !serial_ready_out |=> !out_valid)
    else $error("output produced while processing");

  a_shift_msb_first: assert property (@(posedge mclk) disable iff (!resetn)
    (accept && !is_addr && state == st_shift)
    |=> out_valid && out_byte == $past(resp_top))
    else $error("shift byte not reply top byte");

  // attenuator bytes in their fixed slots, unused slots zero
  a_atten_slots: assert property (@(posedge mclk) disable iff (!resetn)
    (state == st_build && cmd == `REG_PARAM && args[3:0] == `SEL_ATTEN)
    |=> resp[63:48] == 16'h0 && resp[47:40] == $past(params.rf_att1)
        && resp[39:32] == $past(params.rf_att2) && resp[31:24] == 8'h0
        && resp[23:16] == $past(params.ext_if_att)
        && resp[15:0] == {$past(params.if3_att1), $past(params.if3_att2)})
    else $error("attenuator reply layout wrong");

  a_serial_slots: assert property (@(posedge mclk) disable iff (!resetn)
    (state == st_build && cmd == `REG_IDENT && args[3:0] == `ID_SERIAL)
    |=> resp[63:40] == 24'h0 && resp[39:32] == $past(identity.interface_code)
        && resp[31:0] == $past(identity.serial_number))
    else $error("serial number reply layout wrong");

  a_date_halves: assert property (@(posedge mclk) disable iff (!resetn)
    (state == st_build && cmd == `REG_IDENT && args[3:0] == `ID_DATES)
    |=> resp == {$past(identity.cal_date), $past(identity.mfg_date)})
    else $error("date reply layout wrong");

  // the shift frame's own address byte already carries the top reply byte
  a_shift_entry: assert property (@(posedge mclk) disable iff (!resetn)
    (is_addr && in_byte == `REG_SHIFT)
    |=> state == st_shift && arg_cnt == `ARGS_SHIFT && out_valid
        && out_byte == $past(resp_top))
    else $error("shift frame did not start with reply top byte");

  a_read_pop: assert property (@(posedge mclk) disable iff (!resetn)
    (rd_req && state == st_addr && !accept)
    |=> out_valid && out_byte == $past(resp_top) && resp[63:8] == $past(resp[55:0]))
    else $error("parallel read byte wrong");

  a_build_one_cycle: assert property (@(posedge mclk) disable iff (!resetn)
    state == st_build |=> state == st_addr)
    else $error("reply build longer than one cycle");

endmodule
`default_nettype wire

/* verif/host_link_model.sv */
`default_nettype none
module host_link_model (
  input  wire logic       mclk,
  input  wire logic       serial_ready_out,
  output var  logic [7:0] in_byte,
  output var  logic       in_valid,
  output var  logic       in_first,
  output var  logic       rd_req
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle link at time zero
  initial begin
    in_byte = 8'h00;
    in_valid = 1'b0;
    in_first = 1'b0;
    rd_req = 1'b0;
  end

  // poll the ready pin, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    while (serial_ready_out !== 1'b1 && n < 4000) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask

  // byte held until an edge sees ready high
  task automatic send_byte(input logic [7:0] b, input logic f);
    in_byte = b;
    in_first = f;
    in_valid = 1'b1;
    wait_ready();
    @(posedge mclk);
    #1;
  endtask

  // address first, then instruction bytes msb first
  task automatic send_frame(input logic [7:0] a, input logic [55:0] args, input int n);
    send_byte(a, 1'b1);
    for (int i = n - 1; i >= 0; i--) begin
      send_byte(args[i*8+:8], 1'b0);
    end
    in_valid = 1'b0;
    in_first = 1'b0;
    repeat (2) begin
      @(posedge mclk);
      #1;
    end
    wait_ready();
  endtask

  // one parallel pop of the reply
  task automatic pop();
    rd_req = 1'b1;
    @(posedge mclk);
    #1;
    rd_req = 1'b0;
    @(posedge mclk);
    #1;
  endtask
endmodule
`default_nettype wire

/* verif/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import query_pkg::*;

  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  in_byte;
  logic        in_valid;
  logic        in_first;
  logic        rd_req;
  logic        system_active_marker;
  params_s     params;
  status_s     status;
  identity_s   identity;
  store_wr_s   store_wr;
  logic [7:0]  out_byte;
  logic        out_valid;
  logic        serial_ready_out;
  logic [15:0] expq[$];
  logic [15:0] mon_e;
  logic [511:0] rnd;
  logic [63:0] v;
  logic [15:0] base[2];
  int          bad_count;
  int          samples_checked;
  int          cycles;
  int          busy;

  always #2.5 mclk = ~mclk;

  query_register_responder uut (.mclk, .resetn, .in_byte, .in_valid, .in_first, .rd_req,
    .system_active_marker, .params, .status, .identity, .store_wr, .out_byte, .out_valid,
    .serial_ready_out);

  host_link_model host (.mclk, .serial_ready_out, .in_byte, .in_valid, .in_first, .rd_req);

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // monitor: each reply byte against the oldest note
  always @(negedge mclk) begin
    if (out_valid === 1'b1) begin
      if (expq.size() == 0) begin
        check("unexpected out_valid", 8'h01, 8'h00);
      end else begin
        mon_e = expq.pop_front();
        check("out_byte", out_byte & mon_e[15:8], mon_e[7:0] & mon_e[15:8]);
      end
    end
  end

  // cycles spent with ready low
  always @(negedge mclk) begin
    if (serial_ready_out === 1'b0) begin
      busy++;
    end
  end

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic expect_reply(input logic [63:0] ev, input logic [63:0] m);
    for (int i = 7; i >= 0; i--) begin
      expq.push_back({m[i*8+:8], ev[i*8+:8]});
    end
  endtask

  // request frame: every byte echoes zero, ready low only while processing
  task automatic query(input logic [7:0] a, input logic [55:0] args, input int n);
    logic [7:0] eb;
    eb = (a == 8'h35 || a == 8'h36) ? 8'd9 : (a < 8'h34 ? 8'd1 : 8'd0); // fetch or build
    for (int i = 0; i <= n; i++) begin
      expq.push_back(16'hff00);
    end
    busy = 0;
    host.send_frame(a, args, n);
    check("busy cycles", 8'(busy), eb);
  endtask

  task automatic shift_out(input logic [63:0] ev, input logic [63:0] m);
    expect_reply(ev, m);
    host.send_frame(8'h37, 56'h0, 7);
  endtask

  function automatic logic [63:0] pexp(input int s);
    case (s)
      0, 1, 2, 3, 4, 5, 6: pexp = {8'h00, params.freq[s]};
      7: pexp = {16'h0, params.rf_att1, params.rf_att2, 8'h0, params.ext_if_att,
                 params.if3_att1, params.if3_att2};
      8: pexp = {24'h0, params.chain_gain, 8'h0, params.route_word};
      default: pexp = 64'h0;
    endcase
  endfunction

  function automatic logic [63:0] iexp(input int s);
    case (s)
      0: iexp = {24'h0, identity.interface_code, identity.serial_number};
      1: iexp = {identity.fw_revision, identity.hw_revision};
      2: iexp = {identity.cal_date, identity.mfg_date};
      3: iexp = {56'h0, identity.interface_code};
      4: iexp = {32'h0, identity.mfg_date};
      5: iexp = {32'h0, identity.cal_date};
      default: iexp = 64'h0;
    endcase
  endfunction

  function automatic logic [63:0] sexp(input status_s s, input logic a);
    logic [63:0] r;
    r = 64'h0;
    r[7:0] = s.lock_flags;
    r[8] = a;
    r[9] = s.external_lock_on;
    r[10] = s.reference_output_on;
    r[11] = s.reference_output_rate;
    r[14:12] = s.osc_powered;
    r[16:15] = s.synth_loop_gain;
    r[17] = s.quick_tuning;
    r[18] = s.first_oscillator_routed_out;
    r[24] = s.chain_powered;
    r[25] = s.conversion_bypass;
    r[26] = s.external_second_if_select;
    r[27] = s.third_stage_bypass;
    r[29] = s.second_if_filter_choice;
    r[31:30] = s.third_if_bank_one_choice;
    r[32] = s.third_if_bank_two_choice;
    r[33] = s.spectral_inversion;
    r[34] = s.front_amp_on;
    r[35] = s.automatic_gain_on;
    r[36] = s.automatic_front_amp;
    return r;
  endfunction

  function automatic logic [7:0] sdat(input logic r, input logic [15:0] a);
    return a[7:0] ^ 8'h3c ^ (r ? 8'ha5 : 8'h00);
  endfunction

  // main sequence
  initial begin
    system_active_marker = 1'b0;
    store_wr = '0;
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    base[0] = 16'hfffc;
    base[1] = 16'h1230;
    void'($urandom(32'hc811));
    for (int i = 0; i < 16; i++) rnd[i*32+:32] = $urandom;
    params = rnd[$bits(params_s)-1:0];
    status = rnd[511-:$bits(status_s)];
    identity = rnd[300-:$bits(identity_s)];
    repeat (6) @(posedge mclk);
    #1;
    resetn = 1'b1;
    // fill both store regions, one across the address wrap
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 8; k++) begin
        store_wr = '{1'b1, r[0], base[r] + 16'(k), sdat(r[0], base[r] + 16'(k))};
        @(posedge mclk);
        #1;
      end
    end
    store_wr.en = 1'b0;
    for (int s = 0; s < 10; s++) begin
      query(8'h30, 56'(s), 1);
      shift_out(pexp(s), '1);
    end
    query(8'h31, 56'h0, 1);
    shift_out({32'h0, params.temperature}, 64'h0000_0000_ffff_ffff);
    // accessed flag clear, then set by the marker pulse
    for (int k = 0; k < 2; k++) begin
      query(8'h32, 56'h0, 1);
      shift_out(sexp(status, k[0]), 64'h0000_001f_ef07_ffff);
      system_active_marker = 1'b1;
      @(posedge mclk);
      #1;
      system_active_marker = 1'b0;
    end
    // mid-run reset drops an unread reply and the accessed flag
    query(8'h31, 56'h0, 1);
    resetn = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    resetn = 1'b1;
    shift_out(64'h0, '1);
    query(8'h32, 56'h0, 1);
    shift_out(sexp(status, 1'b0), 64'h0000_001f_ef07_ffff);
    for (int s = 0; s < 7; s++) begin
      query(8'h33, 56'(s), 1);
      shift_out(iexp(s), s == 0 ? 64'h0000_00ff_ffff_ffff : '1);
    end
    // parallel readout, ninth pop finds nothing left
    query(8'h33, 56'h1, 1);
    expect_reply(iexp(1), '1);
    expq.push_back(16'hff00);
    repeat (9) host.pop();
    // reserved and unknown addresses start nothing
    for (int k = 0; k < 2; k++) begin
      query(k ? 8'h3f : 8'h34, 56'h0, 1);
      shift_out(64'h0, '1);
    end
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 8; k++) v[k*8+:8] = sdat(r[0], base[r] + 16'(k));
      query(r ? 8'h36 : 8'h35, {32'h0, base[r], 8'h00}, 3);
      shift_out(v, '1);
    end
    repeat (4) @(posedge mclk);
    check("pending replies", 8'(expq.size()), 8'h00);
    complete_run();
  end
endmodule
`default_nettype wire
